//--- pkg/rtc_ctrl_defs.vh
// Constants for the primary control register and the prescaler
`ifndef RTC_CTRL_DEFS_VH
`define RTC_CTRL_DEFS_VH
`define PRIMARY_CONTROL_ADDR   8'h00
`define PRIMARY_CONTROL_RESET  8'h00
`define SOFT_RESET_CMD         8'h58
`define BIT_EXT_CLOCK_TEST_SEL           7
`define BIT_HALT               5
`define BIT_SOFT_RESET         4
`define BIT_CORR_IRQ_EN        2
`define BIT_HOUR_12            1
`define BIT_LOAD_CAP           0
`define READ_MASK              8'ha7
`define PRESCALER_WIDTH        15
`define TEST_TAP               5
`define LOW_STAGES             2
`define CLOCK_OUTPUT_PIN_FAST_TAPS       3
`endif

//--- logic/rtc_control_prescaler.v
// Primary control register and 1 Hz prescaler of the real-time clock
`timescale 1ns/10ps
`include "rtc_ctrl_defs.vh"

// How it works
// - Bit 7 picks normal mode or external clock test mode.
// - Bit 5 halts the clock and clears the upper divider stages, or the whole chain in test mode.
// - Writing 58h to the register starts a software reset; bit 4 reads zero.
// - Bit 2 gates a pulse on every correction cycle onto the interrupt output.
// - Bit 1 selects 12-hour counting when one, 24-hour when zero.
// - Bit 0 selects 12.5 pF load when one, 7 pF when zero.
// - In test mode the clock output pin turns into an input clock source.
// - In test mode the pin clock is divided down to the 1 Hz tick.
// - Halt clears prescaler stages 2 to 14 (all stages in test mode), which stay cleared until halt is released.
// - Test mode after halt: first tick after 32 edges, then every 64.
// - Prescaler state on test mode entry is undefined until a halt.
// - While halted the upper stages sit in reset, so no 1 Hz ticks.
// - While halted clock outputs below 8 kHz are suppressed.
// - While halted time counters accept writes but do not increment.
// - Software reset restores defaults and returns address pointer to zero.
// - Outside test mode, halt leaves the two lowest prescaler stages uncleared.
// - Outside test mode, first tick after halt release comes about half a second later.
module rtc_control_prescaler (
  // Clock and reset
  input  wire       I_CLK,
  input  wire       I_RESET,
  // Register write and read port
  input  wire       I_WR,
  input  wire [7:0] I_ADDR,
  input  wire [7:0] I_WDATA,
  output reg  [7:0] O_RDATA,
  // Oscillator tick at 32.768 kHz, from the oscillator domain
  input  wire       I_OSC,
  // Clock output pin, an input in test mode
  input  wire       I_CLOCK_OUTPUT_PIN_IN,
  output reg        O_CLOCK_OUTPUT_PIN,
  output reg        O_CLOCK_OUTPUT_PIN_OE,
  // Correction cycle event from the offset logic
  input  wire       I_CORR_CYCLE,
  // Outputs to the rest of the clock
  output reg        O_TICK_1HZ,
  output reg        O_CORR_IRQ,
  output reg        O_HOUR_12,
  output reg        O_LOAD_CAP,
  output reg        O_HALTED,
  output reg        O_SOFT_RESET
);

  ////////////////////////////////////////////////////////////////////////
  // Register
  reg  [7:0]  primary_control;
  reg  [1:0]  osc_sync;
  reg  [1:0]  pin_sync;
  reg         osc_prev;
  reg         pin_prev;
  reg  [14:0] prescaler;
  reg  [14:0] next_prescaler;
  reg         top_prev;
  reg         next_tick;
  wire        ext_clock_test_sel = primary_control[`BIT_EXT_CLOCK_TEST_SEL];
  wire        halt               = primary_control[`BIT_HALT];
  wire        reg_write          = I_WR && (I_ADDR == `PRIMARY_CONTROL_ADDR);
  wire        soft_reset_trigger = reg_write && (I_WDATA == `SOFT_RESET_CMD);
  wire        osc_rise           = osc_sync[1] && !osc_prev;
  wire        pin_rise           = pin_sync[1] && !pin_prev;
  wire        step               = ext_clock_test_sel ? pin_rise : osc_rise;

  always @(posedge I_CLK) begin
    if (I_RESET || soft_reset_trigger) begin
      primary_control <= `PRIMARY_CONTROL_RESET;
    end else if (reg_write) begin
      primary_control <= I_WDATA & `READ_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  always @(posedge I_CLK) begin
    if (I_RESET) begin
      osc_sync <= 2'h0;
      pin_sync <= 2'h0;
      osc_prev <= 1'b0;
      pin_prev <= 1'b0;
    end else begin
      osc_sync <= {osc_sync[0], I_OSC};
      pin_sync <= {pin_sync[0], I_CLOCK_OUTPUT_PIN_IN};
      osc_prev <= osc_sync[1];
      pin_prev <= pin_sync[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Prescaler
  always @* begin
    next_prescaler = prescaler;
    if (step) begin
      next_prescaler = prescaler + 15'h0001;
    end
    if (halt) begin
      next_prescaler[14:`LOW_STAGES] = 13'h0000;
    end
    if (ext_clock_test_sel && halt) begin
      next_prescaler = 15'h0000;
    end
  end

  always @* begin
    if (ext_clock_test_sel) begin
      next_tick = !halt && !top_prev && next_prescaler[`TEST_TAP];
    end else begin
      next_tick = !halt && !top_prev && next_prescaler[14];
    end
  end

  always @(posedge I_CLK) begin
    if (I_RESET || soft_reset_trigger) begin
      prescaler  <= 15'h0000;
      top_prev   <= 1'b0;
      O_TICK_1HZ <= 1'b0;
    end else begin
      prescaler  <= next_prescaler;
      top_prev   <= ext_clock_test_sel ? next_prescaler[`TEST_TAP] : next_prescaler[14];
      O_TICK_1HZ <= next_tick;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  always @(posedge I_CLK) begin
    if (I_RESET) begin
      O_RDATA      <= 8'h00;
      O_CLOCK_OUTPUT_PIN     <= 1'b0;
      O_CLOCK_OUTPUT_PIN_OE  <= 1'b1;
      O_CORR_IRQ   <= 1'b0;
      O_HOUR_12    <= 1'b0;
      O_LOAD_CAP   <= 1'b0;
      O_HALTED     <= 1'b0;
      O_SOFT_RESET <= 1'b0;
    end else begin
      O_RDATA      <= primary_control & `READ_MASK;
      O_CLOCK_OUTPUT_PIN     <= halt ? 1'b0 : prescaler[14];
      O_CLOCK_OUTPUT_PIN_OE  <= !ext_clock_test_sel;
      O_CORR_IRQ   <= primary_control[`BIT_CORR_IRQ_EN] && I_CORR_CYCLE;
      O_HOUR_12    <= primary_control[`BIT_HOUR_12];
      O_LOAD_CAP   <= primary_control[`BIT_LOAD_CAP];
      O_HALTED     <= halt;
      O_SOFT_RESET <= soft_reset_trigger;
    end
  end

endmodule // rtc_control_prescaler

//--- dv/rtc_ctrl_props.sv
// Assertions on the control register and prescaler ports
`timescale 1ns/10ps
module rtc_ctrl_props(input wire I_CLK,I_RESET,I_WR,I_OSC,I_CLOCK_OUTPUT_PIN_IN,I_CORR_CYCLE,O_CLOCK_OUTPUT_PIN,O_CLOCK_OUTPUT_PIN_OE,O_TICK_1HZ,
  O_CORR_IRQ,O_HOUR_12,O_LOAD_CAP,O_HALTED,O_SOFT_RESET,input wire [7:0] I_ADDR,I_WDATA,O_RDATA);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (I_RESET);
  sequence s_wr; I_WR && I_ADDR==8'h00; endsequence
  a_rd_mask: assert property (O_RDATA[6]==0 && O_RDATA[4:3]==0) else $error("Unused bit reads one");
  a_wr_echo: assert property (s_wr ##0 I_WDATA!=8'h58 ##1 !I_WR[*2] |=>
    O_RDATA==($past(I_WDATA,3)&8'ha7)) else $error("Readback wrong");
  a_sr_pulse: assert property (s_wr ##0 I_WDATA==8'h58 |-> ##[1:2] O_SOFT_RESET) else $error("No reset pulse");
  a_sr_clear: assert property (O_SOFT_RESET |=> !O_SOFT_RESET && O_RDATA==8'h00) else $error("Reset bad");
  a_irq_cause: assert property (O_CORR_IRQ |-> $past(I_CORR_CYCLE)) else $error("Stray irq");
  a_halt_quiet: assert property (O_HALTED |-> !O_CLOCK_OUTPUT_PIN && !O_TICK_1HZ) else $error("Runs halted");
  a_oe_mode: assert property (O_CLOCK_OUTPUT_PIN_OE == !O_RDATA[7]) else $error("Pin direction wrong");
  a_field_out: assert property ({O_HALTED,O_HOUR_12,O_LOAD_CAP}=={O_RDATA[5],O_RDATA[1:0]}) else $error("Field");
endmodule // rtc_ctrl_props
bind rtc_control_prescaler rtc_ctrl_props i_props(.*);

//--- dv/rtc_pin_source.sv
// External clock source on the clock output pin for test mode
`timescale 1ns/10ps
module rtc_pin_source(input wire logic clk, output logic pin);
  initial pin = 1'b0;
  // 400 ns high, 400 ns low: inside the allowed width and period
  task pulses(input int n);
    repeat (n) begin
      @(negedge clk) pin = 1'b1;
      repeat (8) @(negedge clk);
      pin = 1'b0;
      repeat (7) @(negedge clk);
    end
  endtask
endmodule // rtc_pin_source

//--- dv/tb_rtc_control_and_prescaler.sv
// Testbench for the control register and prescaler
`timescale 1ns/10ps
module tb_rtc_control_and_prescaler;
  logic       I_CLK=0, I_RESET=1, I_WR=0, I_CORR_CYCLE=0, I_OSC=0, pin;
  logic [7:0] I_ADDR=8'h00, I_WDATA=8'h00;
  wire  [7:0] O_RDATA;
  wire        O_CLOCK_OUTPUT_PIN, O_CLOCK_OUTPUT_PIN_OE, O_TICK_1HZ, O_CORR_IRQ, O_HOUR_12, O_LOAD_CAP, O_HALTED, O_SOFT_RESET;
  int         error_cnt=0, num_checks=0, ticks=0, irqs=0, srs=0;
  logic [15:0] rows[6] = '{16'h0101, 16'h0202, 16'h0404, 16'hffa7, 16'h4800, 16'h2020};
  rtc_control_prescaler i_dut(.I_CLK, .I_RESET, .I_WR, .I_ADDR, .I_WDATA, .O_RDATA, .I_OSC,
    .I_CLOCK_OUTPUT_PIN_IN(O_CLOCK_OUTPUT_PIN_OE ? O_CLOCK_OUTPUT_PIN : pin), .O_CLOCK_OUTPUT_PIN, .O_CLOCK_OUTPUT_PIN_OE, .I_CORR_CYCLE, .O_TICK_1HZ,
    .O_CORR_IRQ, .O_HOUR_12, .O_LOAD_CAP, .O_HALTED, .O_SOFT_RESET);
  rtc_pin_source i_src(.clk(I_CLK), .pin(pin));
  initial forever #25 I_CLK = ~I_CLK;
  always @(posedge I_CLK) begin
    ticks += (O_TICK_1HZ === 1'b1);
    irqs += (O_CORR_IRQ === 1'b1);
    srs += (O_SOFT_RESET === 1'b1);
  end
  task wr(input logic [7:0] a, d);
    @(negedge I_CLK) {I_WR, I_ADDR, I_WDATA} = {1'b1, a, d};
    @(negedge I_CLK) I_WR = 1'b0;
    repeat (2) @(negedge I_CLK);
  endtask
  task chk(input logic [7:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task report_and_stop;
    $display("checks=%0d mismatches=%0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    #2500000 error_cnt++;
    report_and_stop;
  end
  initial begin
    repeat (3) @(negedge I_CLK);
    I_RESET = 0;
    @(negedge I_CLK) chk(O_RDATA, 8'h00);
    chk({7'h0, O_CLOCK_OUTPUT_PIN_OE}, 8'h01);
    foreach (rows[i]) begin
      wr(8'h00, rows[i][15:8]);
      chk(O_RDATA, rows[i][7:0]);
      chk({5'h0, O_HALTED, O_HOUR_12, O_LOAD_CAP}, {5'h0, rows[i][5], rows[i][1:0]});
    end
    $display("register rows done");
    wr(8'h01, 8'hff);
    chk(O_RDATA, 8'h20);
    wr(8'h00, 8'h07);
    wr(8'h00, 8'h58);
    chk(O_RDATA, 8'h00);
    chk(srs[7:0], 8'h01);
    $display("soft reset done");
    for (int k = 0; k < 2; k++) begin
      wr(8'h00, k ? 8'h00 : 8'h04);
      @(negedge I_CLK) I_CORR_CYCLE = 1'b1;
      @(negedge I_CLK) I_CORR_CYCLE = 1'b0;
      repeat (3) @(negedge I_CLK);
    end
    chk(irqs[7:0], 8'h01);
    wr(8'h00, 8'ha0);
    chk({7'h0, O_CLOCK_OUTPUT_PIN_OE}, 8'h00);
    wr(8'h00, 8'h80);
    ticks = 0;
    i_src.pulses(31);
    repeat (6) @(negedge I_CLK);
    chk(ticks[7:0], 8'h00);
    i_src.pulses(1);
    repeat (6) @(negedge I_CLK);
    chk(ticks[7:0], 8'h01);
    i_src.pulses(64);
    repeat (6) @(negedge I_CLK);
    chk(ticks[7:0], 8'h02);
    wr(8'h00, 8'ha0);
    i_src.pulses(64);
    chk(ticks[7:0], 8'h02);
    $display("test mode done");
    wr(8'h00, 8'h20);
    wr(8'h00, 8'h00);
    ticks = 0;
    repeat (32600) @(negedge I_CLK) I_OSC = ~I_OSC;
    chk(ticks[7:0], 8'h00);
    repeat (400) @(negedge I_CLK) I_OSC = ~I_OSC;
    chk(ticks[7:0], 8'h01);
    chk({7'h0, O_CLOCK_OUTPUT_PIN}, 8'h01);
    $display("normal mode done");
    report_and_stop;
  end
endmodule // tb_rtc_control_and_prescaler
